//--- eqc_pkg.sv
// Constants and carriers for the equalizer control register bank
package eqc_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] EQC_OFS_TAP0      = 8'h00;
	localparam logic [7:0] EQC_OFS_TAP_LAST  = 8'h08;
	localparam logic [7:0] EQC_OFS_PREDRV    = 8'h09;
	localparam logic [7:0] EQC_OFS_GLOBAL    = 8'h80;
	localparam logic [7:0] EQC_PTR_DEFAULT   = 8'h00;
	localparam logic [7:0] EQC_PTR_STEP      = 8'h01;
	localparam int         EQC_NUM_TAPS      = 9;
	localparam int         EQC_TAP_FULL      = 4;

	// ==========================================================
	// Field positions
	localparam int EQC_TAP_EN_BIT     = 7;
	localparam int EQC_TAP_SIGN_BIT   = 6;
	localparam int EQC_GLB_ADDR_CMD   = 6;
	localparam int EQC_GLB_ADDR1_RD   = 7;
	localparam int EQC_GLB_ADDR0_RD   = 6;
	localparam int EQC_GLB_CH1_EN     = 5;
	localparam int EQC_GLB_CH0_EN     = 4;
	localparam int EQC_GLB_FACT3      = 3;
	localparam int EQC_GLB_CH1_RST    = 2;
	localparam int EQC_GLB_CH0_RST    = 1;
	localparam int EQC_GLB_GRST       = 0;

	// ==========================================================
	// Reset values
	localparam logic [7:0] EQC_TAP_RST      = 8'hC0;
	localparam logic [7:0] EQC_TAP_FULL_RST = 8'hFF;
	localparam logic [7:0] EQC_PREDRV_RST   = 8'h30;
	localparam logic [1:0] EQC_ADDR_RST     = 2'h0;
	localparam logic       EQC_GLB_BIT_RST  = 1'b1;
	localparam logic [7:0] EQC_UNMAPPED_RD  = 8'h00;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic       start;
		logic       start_rd;
		logic       stop;
		logic       ptr_wr;
		logic       wr_en;
		logic       rd_en;
		logic [7:0] data;
	} eqc_bus_req_t;

	typedef struct packed {
		logic       en;
		logic       sign_pos;
		logic [5:0] gain;
	} eqc_tap_t;

	typedef struct packed {
		logic ch1_en;
		logic ch0_en;
		logic ch1_srst_n;
		logic ch0_srst_n;
		logic glb_srst_n;
	} eqc_ctrl_t;

endpackage

//--- eqc_regs.sv
// Channel 0 array A and global control register bank of the dual-channel equalizer
// ==========================================================
// Behaviour
// - Global register read layout differs from write
// - Writing bit 6 loads device address readback
// - Read bits 7 and 6 return address bits
// - Bit 5 enables channel 1, default 1
// - Bit 4 enables channel 0, default 1
// - Bit 2 low soft-resets channel 1
// - Bit 1 low soft-resets channel 0
// - Bit 0 low soft-resets whole device
// - Tap register holds enable, sign, gain
// - Sign one is positive, zero negative
// - Taps default enabled positive zero, tap4 full
// - Predriver gain six bits, default 0x30
// - Hard reset pin restores all defaults
// - Pointer advances after each data byte
// - Read without pointer write starts at zero
`timescale 1ns/1ps

module eqc_regs (
	input  wire logic                                     clk_in,
	input  wire logic                                     resetn_in,
	input  wire eqc_pkg::eqc_bus_req_t                    bus_in,
	input  wire logic [1:0]                               dev_addr_in,
	output logic [7:0]                                    rd_byte_out,
	output eqc_pkg::eqc_tap_t [eqc_pkg::EQC_NUM_TAPS-1:0] taps_out,
	output logic signed [6:0]                             tap_coef_out [eqc_pkg::EQC_NUM_TAPS],
	output logic [5:0]                                    predrv_gain_out,
	output eqc_pkg::eqc_ctrl_t                            ctrl_out
);
	import eqc_pkg::*;

	// ==========================================================
	// Reset release
	logic       rst_meta_reg;
	logic       rst_n;
	logic [1:0] addr_meta_reg;
	logic [1:0] addr_sync_reg;

	// Assertion is immediate, release waits two edges to avoid metastable exit
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	// Address straps are pins, so they are synchronised before use
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			addr_meta_reg <= 2'h0;
			addr_sync_reg <= 2'h0;
		end else begin
			addr_meta_reg <= dev_addr_in;
			addr_sync_reg <= addr_meta_reg;
		end
	end

	// ==========================================================
	// Helpers
	function automatic logic [7:0] eqc_tap_default(input int idx);
		eqc_tap_default = (idx == EQC_TAP_FULL) ? EQC_TAP_FULL_RST : EQC_TAP_RST;
	endfunction

	function automatic logic is_tap(input logic [7:0] ofs);
		is_tap = (ofs <= EQC_OFS_TAP_LAST);
	endfunction

	function automatic logic signed [6:0] tap_coef(input logic [7:0] tap);
		logic [6:0] mag;
		mag = {1'b0, tap[5:0]};
		// Sign high means positive gain
		tap_coef = tap[EQC_TAP_SIGN_BIT] ? $signed(mag) : -$signed(mag);
	endfunction

	// ==========================================================
	// Register pointer
	logic [7:0] ptr_reg;
	logic       ptr_valid_reg;

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ptr_reg <= EQC_PTR_DEFAULT;
		end else if (bus_in.start && bus_in.start_rd && !ptr_valid_reg) begin
			ptr_reg <= EQC_PTR_DEFAULT;
		end else if (bus_in.ptr_wr) begin
			ptr_reg <= bus_in.data;
		end else if (bus_in.wr_en || bus_in.rd_en) begin
			ptr_reg <= ptr_reg + EQC_PTR_STEP;
		end
	end

	// A pointer written in one transfer serves the following read; a read start ends it
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ptr_valid_reg <= 1'b0;
		end else if (bus_in.ptr_wr) begin
			ptr_valid_reg <= 1'b1;
		end else if (bus_in.start && bus_in.start_rd) begin
			ptr_valid_reg <= 1'b0;
		end
	end

	logic wr_global;
	assign wr_global = bus_in.wr_en && (ptr_reg == EQC_OFS_GLOBAL);

	// ==========================================================
	// Global register
	logic       grst_reg;
	logic       ch0_rst_reg;
	logic       ch1_rst_reg;
	logic       ch0_en_reg;
	logic       ch1_en_reg;
	logic       fact3_reg;
	logic [1:0] addr_rb_reg;

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			grst_reg <= EQC_GLB_BIT_RST;
		end else if (wr_global) begin
			grst_reg <= bus_in.data[EQC_GLB_GRST];
		end
	end

	// Other global fields sit at default while the global soft reset is low
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ch0_rst_reg <= EQC_GLB_BIT_RST;
			ch1_rst_reg <= EQC_GLB_BIT_RST;
			ch0_en_reg  <= EQC_GLB_BIT_RST;
			ch1_en_reg  <= EQC_GLB_BIT_RST;
			fact3_reg   <= EQC_GLB_BIT_RST;
		end else if (!grst_reg || (wr_global && !bus_in.data[EQC_GLB_GRST])) begin
			ch0_rst_reg <= EQC_GLB_BIT_RST;
			ch1_rst_reg <= EQC_GLB_BIT_RST;
			ch0_en_reg  <= EQC_GLB_BIT_RST;
			ch1_en_reg  <= EQC_GLB_BIT_RST;
			fact3_reg   <= EQC_GLB_BIT_RST;
		end else if (wr_global) begin
			ch0_rst_reg <= bus_in.data[EQC_GLB_CH0_RST];
			ch1_rst_reg <= bus_in.data[EQC_GLB_CH1_RST];
			ch0_en_reg  <= bus_in.data[EQC_GLB_CH0_EN];
			ch1_en_reg  <= bus_in.data[EQC_GLB_CH1_EN];
			fact3_reg   <= bus_in.data[EQC_GLB_FACT3];
		end
	end

	// Readback of the strap address only refreshes on command
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			addr_rb_reg <= EQC_ADDR_RST;
		end else if (!grst_reg || (wr_global && !bus_in.data[EQC_GLB_GRST])) begin
			addr_rb_reg <= EQC_ADDR_RST;
		end else if (wr_global && bus_in.data[EQC_GLB_ADDR_CMD]) begin
			addr_rb_reg <= addr_sync_reg;
		end
	end

	// ==========================================================
	// Channel 0 array A
	logic [7:0] tap_reg [EQC_NUM_TAPS];
	logic [7:0] predrv_reg;
	logic       ch0_hold;

	// Either soft reset holds the channel; writes are dropped meanwhile
	assign ch0_hold = !grst_reg || !ch0_rst_reg;

	genvar gi;
	generate
		for (gi = 0; gi < EQC_NUM_TAPS; gi++) begin : g_tap
			always_ff @(posedge clk_in or negedge rst_n) begin
				if (!rst_n) begin
					tap_reg[gi] <= eqc_tap_default(gi);
				end else if (ch0_hold) begin
					tap_reg[gi] <= eqc_tap_default(gi);
				end else if (bus_in.wr_en && is_tap(ptr_reg) && (ptr_reg[3:0] == 4'(gi))) begin
					tap_reg[gi] <= bus_in.data;
				end
			end

			assign taps_out[gi]     = eqc_tap_t'(tap_reg[gi]);
			assign tap_coef_out[gi] = tap_coef(tap_reg[gi]);
		end
	endgenerate

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			predrv_reg <= EQC_PREDRV_RST;
		end else if (ch0_hold) begin
			predrv_reg <= EQC_PREDRV_RST;
		end else if (bus_in.wr_en && (ptr_reg == EQC_OFS_PREDRV)) begin
			predrv_reg <= bus_in.data;
		end
	end

	assign predrv_gain_out = predrv_reg[5:0];

	// ==========================================================
	// Read path
	logic [7:0] glb_rd;
	logic [7:0] rd_mux;
	logic [7:0] rd_byte_reg;

	// Address bits occupy the top of the read layout, unlike the write layout
	assign glb_rd = {addr_rb_reg[1], addr_rb_reg[0], ch1_en_reg, ch0_en_reg,
		fact3_reg, ch1_rst_reg, ch0_rst_reg, grst_reg};

	always_comb begin
		rd_mux = EQC_UNMAPPED_RD;
		if (is_tap(ptr_reg)) begin
			rd_mux = tap_reg[ptr_reg[3:0]];
		end else if (ptr_reg == EQC_OFS_PREDRV) begin
			rd_mux = predrv_reg;
		end else if (ptr_reg == EQC_OFS_GLOBAL) begin
			rd_mux = glb_rd;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rd_byte_reg <= EQC_UNMAPPED_RD;
		end else if (bus_in.rd_en) begin
			rd_byte_reg <= rd_mux;
		end
	end

	assign rd_byte_out         = rd_byte_reg;
	assign ctrl_out.ch0_en     = ch0_en_reg;
	assign ctrl_out.ch1_en     = ch1_en_reg;
	assign ctrl_out.ch0_srst_n = ch0_rst_reg && grst_reg;
	assign ctrl_out.ch1_srst_n = ch1_rst_reg && grst_reg;
	assign ctrl_out.glb_srst_n = grst_reg;

	// ==========================================================
	// Checks
	glb_read_layout_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		bus_in.rd_en && ptr_reg == EQC_OFS_GLOBAL |=> rd_byte_out[2:0] == {ch1_rst_reg, ch0_rst_reg, grst_reg})
		else $error("Global read layout wrong");

	addr_readback_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		bus_in.rd_en && ptr_reg == EQC_OFS_GLOBAL |=>
		rd_byte_out[EQC_GLB_ADDR1_RD:EQC_GLB_ADDR0_RD] == $past(addr_rb_reg))
		else $error("Address bits not at top of global read");

	addr_cmd_load_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		wr_global && bus_in.data[EQC_GLB_ADDR_CMD] && bus_in.data[EQC_GLB_GRST] && grst_reg
		|=> addr_rb_reg == $past(addr_sync_reg))
		else $error("Address readback command not loaded");

	addr_cmd_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		grst_reg && !(wr_global && (bus_in.data[EQC_GLB_ADDR_CMD] || !bus_in.data[EQC_GLB_GRST]))
		|=> $stable(addr_rb_reg))
		else $error("Address readback changed without command");

	ch1_enable_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		wr_global && grst_reg && bus_in.data[EQC_GLB_GRST] |=> ctrl_out.ch1_en == $past(bus_in.data[EQC_GLB_CH1_EN]))
		else $error("Channel 1 enable not written");

	ch0_enable_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		wr_global && grst_reg && bus_in.data[EQC_GLB_GRST] |=> ctrl_out.ch0_en == $past(bus_in.data[EQC_GLB_CH0_EN]))
		else $error("Channel 0 enable not written");

	ch1_srst_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		wr_global && grst_reg && bus_in.data[EQC_GLB_GRST] && !bus_in.data[EQC_GLB_CH1_RST]
		|=> !ctrl_out.ch1_srst_n)
		else $error("Channel 1 soft reset not issued");

	ch0_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		ch0_hold |=> tap_reg[EQC_TAP_FULL] == EQC_TAP_FULL_RST && predrv_reg == EQC_PREDRV_RST)
		else $error("Channel 0 not held at defaults");

	glb_srst_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		!grst_reg |=> ch0_en_reg && ch1_en_reg && ch0_rst_reg && ch1_rst_reg && addr_rb_reg == EQC_ADDR_RST)
		else $error("Global soft reset left a field changed");

	tap_write_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		bus_in.wr_en && ptr_reg == EQC_OFS_TAP0 && !ch0_hold ##1 !ch0_hold |-> tap_reg[0] == $past(bus_in.data))
		else $error("Tap 0 write lost");

	coef_sign_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		taps_out[0].gain != 6'h00 |-> (tap_coef_out[0] > 7'sh00) == taps_out[0].sign_pos)
		else $error("Tap sign interpreted wrongly");

	ptr_advance_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		(bus_in.wr_en || bus_in.rd_en) && !bus_in.ptr_wr && !bus_in.start |=> ptr_reg == $past(ptr_reg) + EQC_PTR_STEP)
		else $error("Pointer did not advance");

	read_start_a: assert property (@(posedge clk_in) disable iff (!rst_n)
		bus_in.start && bus_in.start_rd && !ptr_valid_reg |=> ptr_reg == EQC_PTR_DEFAULT)
		else $error("Read without pointer write not at zero");

endmodule

//--- eqc_host_model.sv
// Byte engine model that drives request strobes into the register bank
`timescale 1ns/1ps

module eqc_host_model (
	input  wire logic             clk_in,
	input  wire logic [7:0]       rd_byte_in,
	output eqc_pkg::eqc_bus_req_t bus_out
);
	import eqc_pkg::*;

	// ==========================================================
	// Idle bus
	// Lines stay quiet from time zero and around any hard reset pulse
	initial bus_out = '0;

	// ==========================================================
	// Strobes
	// Each call waits an edge first, so no signal is set twice in one step
	task automatic send(input logic [5:0] f, input logic [7:0] d);
		@(posedge clk_in);
		#1;
		bus_out = {f, d};
	endtask

	task automatic idle();
		send(6'h00, 8'h00);
	endtask

	// Callers keep factory bits at their defaults
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		send(6'h04, a);
		send(6'h02, d);
		idle();
	endtask

	task automatic read(input logic [7:0] a, input logic use_ptr, output logic [7:0] d);
		if (use_ptr) begin
			send(6'h04, a);
		end
		send(6'h30, 8'h00);
		send(6'h01, 8'h00);
		idle();
		d = rd_byte_in;
	endtask
endmodule

//--- eqc_regs_test.sv
// Self-checking bench for the equalizer control register bank
`timescale 1ns/1ps

module eqc_regs_test;
	import eqc_pkg::*;

	logic                        clk_in;
	logic                        resetn_in;
	logic [1:0]                  dev_addr_in;
	eqc_bus_req_t                bus_in;
	logic [7:0]                  rd_byte_out;
	eqc_tap_t [EQC_NUM_TAPS-1:0] taps_out;
	logic signed [6:0]           tap_coef_out [EQC_NUM_TAPS];
	logic [5:0]                  predrv_gain_out;
	eqc_ctrl_t                   ctrl_out;
	int                          num_errors = 0;
	int                          tests_run = 0;
	int                          cycles = 0;
	logic [7:0]                  d;

	eqc_regs u_eqc_regs (
		.clk_in          (clk_in),
		.resetn_in       (resetn_in),
		.bus_in          (bus_in),
		.dev_addr_in     (dev_addr_in),
		.rd_byte_out     (rd_byte_out),
		.taps_out        (taps_out),
		.tap_coef_out    (tap_coef_out),
		.predrv_gain_out (predrv_gain_out),
		.ctrl_out        (ctrl_out)
	);

	eqc_host_model u_host (
		.clk_in     (clk_in),
		.rd_byte_in (rd_byte_out),
		.bus_out    (bus_in)
	);

	// ==========================================================
	// Clock and watchdog
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			num_errors++;
			final_report();
		end
	end

	// ==========================================================
	// Helpers
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		if (num_errors == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Write global, then compare control outputs and the read layout
	task automatic glb(input logic [7:0] w, input logic [7:0] rexp, input logic [4:0] cexp);
		u_host.write(EQC_OFS_GLOBAL, w);
		check({3'h0, ctrl_out}, {3'h0, cexp});
		u_host.read(EQC_OFS_GLOBAL, 1'b1, d);
		check(d, rexp);
	endtask

	// ==========================================================
	// Sequence
	initial begin
		resetn_in = 1'b0;
		dev_addr_in = 2'b10;
		repeat (16) @(posedge clk_in);
		#1;
		resetn_in = 1'b1;
		repeat (6) @(posedge clk_in);
		#1;
		check({3'h0, ctrl_out}, 8'h1F);
		check(taps_out[4], 8'hFF);
		check({1'b0, tap_coef_out[4]}, 8'h3F);
		// Burst read from zero with no pointer byte, back to back
		u_host.send(6'h30, 8'h00);
		for (int i = 0; i <= 10; i++) begin
			if (i < 10) begin
				u_host.send(6'h01, 8'h00);
			end else begin
				u_host.idle();
			end
			if (i > 0) begin
				check(rd_byte_out, (i == EQC_TAP_FULL + 1) ? 8'hFF : (i == 10) ? 8'h30 : 8'hC0);
			end
		end
		u_host.read(EQC_OFS_GLOBAL, 1'b1, d);
		check(d, 8'h3F);
		// Two data bytes after one pointer byte
		u_host.send(6'h04, 8'h02);
		u_host.send(6'h02, 8'h85);
		u_host.send(6'h02, 8'h7F);
		u_host.idle();
		check(taps_out[2], 8'h85);
		check(taps_out[3], 8'h7F);
		check({1'b0, tap_coef_out[2]}, 8'h7B);
		check({1'b0, tap_coef_out[3]}, 8'h3F);
		u_host.read(8'h03, 1'b1, d);
		check(d, 8'h7F);
		u_host.read(8'h00, 1'b0, d);
		check(d, 8'hC0);
		// Tap 0 with a nonzero negative gain
		u_host.write(EQC_OFS_TAP0, 8'h05);
		check(taps_out[0], 8'h05);
		check({1'b0, tap_coef_out[0]}, 8'h7B);
		u_host.read(8'h81, 1'b1, d);
		check(d, 8'h00);
		// Global fields and address readback
		glb(8'h5F, 8'h9F, 5'h0F);
		// New strap value must not show until the next command
		dev_addr_in = 2'b01;
		glb(8'h2F, 8'hAF, 5'h17);
		glb(8'h3D, 8'hBD, 5'h1D);
		check(taps_out[2], 8'hC0);
		u_host.write(8'h03, 8'h11);
		check(taps_out[3], 8'hC0);
		glb(8'h3F, 8'hBF, 5'h1F);
		check(taps_out[3], 8'hC0);
		u_host.write(8'h03, 8'h11);
		check(taps_out[3], 8'h11);
		glb(8'h3B, 8'hBB, 5'h1B);
		glb(8'h3F, 8'hBF, 5'h1F);
		glb(8'h7F, 8'h7F, 5'h1F);
		u_host.write(EQC_OFS_PREDRV, 8'h15);
		check({2'h0, predrv_gain_out}, 8'h15);
		u_host.read(EQC_OFS_PREDRV, 1'b1, d);
		check(d, 8'h15);
		glb(8'h3E, 8'h3E, 5'h18);
		check(taps_out[3], 8'hC0);
		check({2'h0, predrv_gain_out}, 8'h30);
		glb(8'h3F, 8'h3F, 5'h1F);
		// Hard reset in mid-run takes effect without a clock edge
		u_host.write(EQC_OFS_PREDRV, 8'h21);
		u_host.write(8'h03, 8'h22);
		glb(8'h1F, 8'h1F, 5'h0F);
		@(posedge clk_in);
		#1;
		resetn_in = 1'b0;
		#1;
		check({2'h0, predrv_gain_out}, 8'h30);
		check(taps_out[3], 8'hC0);
		check({3'h0, ctrl_out}, 8'h1F);
		@(posedge clk_in);
		#1;
		resetn_in = 1'b1;
		repeat (6) @(posedge clk_in);
		u_host.read(EQC_OFS_GLOBAL, 1'b1, d);
		check(d, 8'h3F);
		final_report();
	end
endmodule
